// >>> rtl/pcc_core.sv
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// - one reset width, 20 ms or 1 ms, filters both reset inputs
// - each count pulse adds the prescale factor, range 0.001 to 99.999, or to 9.999 in four-digit
// - one polarity setting applies to every external input
// - value colour follows colour setting and output state, stage two in two-stage
// - swap off: stage one to transistor; swap on with the two-stage bit set: exchanged
// - lock switch on blocks keys per lock level one to five
// - lock indicator lit while the lock switch is on
// - config mode needs mode plus up 1 s, function mode 3 s
// - digit keys step each digit of set value two 0 to 9 with wrap
// - present value reaching a set value asserts its output per mode
// - batch counter counts completions, stage one on at batch set value
// - dual value is A plus B, or A minus B
// - dual value reaching dual set value drives the outputs
// - single units act as stage two; single, total, dual switch both
// - present value wraps to zero past full scale, 999999 or 9999
// - no counting on input A while primary reset is asserted
// - primary reset ends an active one-shot at once
// - outputs on before power loss come back on; ctrl is reset then, so no one-shot restarts
// - one-shot time programmable 0.01 to 99.99 s
// - total counter accumulates, not cleared by preset completion
// - count rate 30 Hz or 5 kHz for both inputs, level width filtered at either rate
// - in total mode secondary reset clears only the total
module pcc_core #(
    parameter int RST_LONG = pcc_pkg::RST_LONG_CYC,
    parameter int RST_SHORT = pcc_pkg::RST_SHORT_CYC,
    parameter int HOLD_CONFIG = pcc_pkg::HOLD_CONFIG_CYC,
    parameter int HOLD_FUNC = pcc_pkg::HOLD_FUNC_CYC,
    parameter int RATE_LOW = pcc_pkg::RATE_LOW_CYC,
    parameter int RATE_HIGH = pcc_pkg::RATE_HIGH_CYC,
    parameter int OS_TICK = pcc_pkg::OS_TICK_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic count_input_a,
    input wire logic count_input_b,
    input wire logic reset_in_one,
    input wire logic reset_in_two,
    input wire logic key_mode,
    input wire logic key_up,
    input wire logic key_reset,
    input wire logic key_display,
    input wire logic lock_switch,
    input wire logic restore_one,
    input wire logic restore_two,
    output logic transistor_out,
    output logic contact_out,
    output logic value_red,
    output logic value_green,
    output logic lock_lit,
    output logic config_mode_req,
    output logic func_mode_req,
    output logic display_next
);
    localparam int W = 24;
    initial begin
        if (RST_LONG < 1 || RST_SHORT < 1 || RATE_LOW < 1 || RATE_HIGH < 1 || OS_TICK < 1
            || HOLD_CONFIG < 1 || HOLD_FUNC <= HOLD_CONFIG)
            $error("pcc_core: bad timing parameters");
    end

    logic [15:0] ctrl;
    logic [16:0] prescale;
    logic [19:0] set_value_one, set_value_two, batch_set;
    logic [13:0] os_time;
    logic [19:0] pv, total, batch, pv_b;
    logic [9:0] frac, frac_b, frac_t;
    logic stage1_output, stage2_output, os_active, batch_done;
    logic [13:0] os_left;
    logic [31:0] os_tick_cnt;

    wire four = ctrl[pcc_pkg::C_FOUR];
    wire [19:0] full_scale = four ? pcc_pkg::FULL_SCALE_FOUR : pcc_pkg::FULL_SCALE_SIX;
    wire [2:0] cfg = ctrl[pcc_pkg::C_CFG_LO +: 3];
    wire [2:0] lock_level = ctrl[pcc_pkg::C_LOCK_LO +: 3];
    wire is_dual = cfg == pcc_pkg::PCC_CFG_DUAL;
    wire is_total = cfg == pcc_pkg::PCC_CFG_TOTAL;
    wire is_batch = cfg == pcc_pkg::PCC_CFG_BATCH;
    wire is_two = cfg == pcc_pkg::PCC_CFG_TWO;

    // input conditioning: three flops, change taken when stages two and three agree
    logic [2:0] s_a, s_b, s_r1, s_r2, s_km, s_ku, s_kr, s_kd, s_ls;
    logic [8:0] lvl;
    wire [8:0] raw = {count_input_a, count_input_b, reset_in_one, reset_in_two,
                      key_mode, key_up, key_reset, key_display, lock_switch};
    // polarity: sourcing inputs are active high, sinking ones pull low
    wire [8:0] act = raw ^ {9{~ctrl[pcc_pkg::C_SOURCING]}};
    always_ff @(posedge mclk) begin
        s_a <= {s_a[1:0], act[8]};
        s_b <= {s_b[1:0], act[7]};
        s_r1 <= {s_r1[1:0], act[6]};
        s_r2 <= {s_r2[1:0], act[5]};
        s_km <= {s_km[1:0], act[4]};
        s_ku <= {s_ku[1:0], act[3]};
        s_kr <= {s_kr[1:0], act[2]};
        s_kd <= {s_kd[1:0], act[1]};
        s_ls <= {s_ls[1:0], act[0]};
    end
    wire [8:0] agree = {s_a[1] ~^ s_a[2], s_b[1] ~^ s_b[2], s_r1[1] ~^ s_r1[2],
                        s_r2[1] ~^ s_r2[2], s_km[1] ~^ s_km[2], s_ku[1] ~^ s_ku[2],
                        s_kr[1] ~^ s_kr[2], s_kd[1] ~^ s_kd[2], s_ls[1] ~^ s_ls[2]};
    wire [8:0] third = {s_a[2], s_b[2], s_r1[2], s_r2[2], s_km[2], s_ku[2], s_kr[2],
                        s_kd[2], s_ls[2]};
    always_ff @(posedge mclk) begin
        if (rst)
            lvl <= '0;
        else
            lvl <= (agree & third) | (~agree & lvl);
    end

    // width filters: counts and resets must hold a level for the selected time
    wire [31:0] rate_cyc = ctrl[pcc_pkg::C_RATE_HIGH] ? RATE_HIGH : RATE_LOW;
    wire [31:0] rst_cyc = ctrl[pcc_pkg::C_RST_SHORT] ? RST_SHORT : RST_LONG;
    logic [3:0] filt;
    logic [3:0] filt_rise;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_filt
            logic [31:0] cnt;
            wire src = lvl[5 + gi];
            wire [31:0] lim = (gi >= 2) ? rate_cyc : rst_cyc;
            always_ff @(posedge mclk) begin
                if (rst) begin
                    cnt <= '0;
                    filt[gi] <= 1'b0;
                    filt_rise[gi] <= 1'b0;
                end else begin
                    filt_rise[gi] <= 1'b0;
                    if (src == filt[gi])
                        cnt <= '0;
                    else if (cnt + 32'h1 >= lim) begin
                        cnt <= '0;
                        filt[gi] <= src;
                        filt_rise[gi] <= src;
                    end else
                        cnt <= cnt + 32'h1;
                end
            end
        end
    endgenerate
    wire res1 = filt[1];
    wire res2 = filt[0];
    wire pulse_a = filt_rise[3];
    wire pulse_b = filt_rise[2];

    // key protection
    wire locked = lvl[0];
    wire blk_mode = locked;
    wire blk_reset = locked && (lock_level == pcc_pkg::LOCK_TWO ||
                     lock_level == pcc_pkg::LOCK_FOUR || lock_level == pcc_pkg::LOCK_FIVE);
    wire blk_up = locked && (lock_level == pcc_pkg::LOCK_THREE ||
                  lock_level == pcc_pkg::LOCK_FOUR || lock_level == pcc_pkg::LOCK_FIVE);
    wire blk_disp = locked && lock_level == pcc_pkg::LOCK_FIVE;
    logic k_reset_d, k_disp_d;
    wire key_reset_ev = lvl[2] && !k_reset_d && !blk_reset;
    logic [31:0] hold_cnt;
    wire hold_up = lvl[4] && lvl[3];

    // mode key timing
    always_ff @(posedge mclk) begin
        if (rst) begin
            hold_cnt <= '0;
            config_mode_req <= 1'b0;
            func_mode_req <= 1'b0;
            k_reset_d <= 1'b0;
            k_disp_d <= 1'b0;
            display_next <= 1'b0;
            lock_lit <= 1'b0;
        end else begin
            k_reset_d <= lvl[2];
            k_disp_d <= lvl[1];
            display_next <= lvl[1] && !k_disp_d && !blk_disp;
            lock_lit <= locked;
            hold_cnt <= (lvl[4] && !blk_mode && hold_cnt < HOLD_FUNC) ? hold_cnt + 32'h1
                        : (lvl[4] ? hold_cnt : '0);
            config_mode_req <= hold_up && !blk_mode && hold_cnt == HOLD_CONFIG - 1;
            func_mode_req <= !lvl[3] && !blk_mode && hold_cnt == HOLD_FUNC - 1;
        end
    end

    // prescaled counting: fraction kept in thousandths
    function automatic logic [29:0] add_scaled(input logic [19:0] v, input logic [9:0] f,
                                               input logic [16:0] s, input logic [19:0] fs);
        logic [31:0] t;
        logic [31:0] whole;
        t = {12'h0, v} * 32'd1000 + {22'h0, f} + {15'h0, s};
        whole = t / 32'd1000;
        if (whole > {12'h0, fs})
            whole = whole - {12'h0, fs} - 32'h1;
        add_scaled = {whole[19:0], 10'(t % 32'd1000)};
    endfunction
    wire [29:0] next_a = add_scaled(pv, frac, prescale, full_scale);
    wire [29:0] next_b = add_scaled(pv_b, frac_b, prescale, full_scale);
    wire [29:0] next_t = add_scaled(total, frac_t, prescale, full_scale);
    wire [20:0] dual_add = {1'b0, pv} + {1'b0, pv_b};
    wire [20:0] dual_sub = {1'b0, pv} - {1'b0, pv_b};
    wire [20:0] dual_val = ctrl[pcc_pkg::C_SUB] ? dual_sub : dual_add;
    wire [20:0] dual_set = {1'b0, set_value_two};
    wire reach2 = is_dual ? (dual_val == dual_set)
                          : (next_a[29:10] >= set_value_two && pulse_a && !res1);
    wire reach1 = is_two && pulse_a && !res1 && next_a[29:10] >= set_value_one;
    wire complete = !is_dual && reach2;
    wire [19:0] next_batch = (batch == full_scale) ? 20'h0 : batch + 20'h1;

    always_ff @(posedge mclk) begin
        if (rst) begin
            pv <= '0;
            frac <= '0;
            pv_b <= '0;
            frac_b <= '0;
            total <= '0;
            frac_t <= '0;
            batch <= '0;
            batch_done <= 1'b0;
        end else begin
            if (res1 || key_reset_ev) begin
                pv <= '0;
                frac <= '0;
            end else if (complete && !is_total && !is_batch) begin
                pv <= next_a[29:10];
                frac <= next_a[9:0];
            end else if (complete) begin
                pv <= '0;
                frac <= '0;
            end else if (pulse_a) begin
                pv <= next_a[29:10];
                frac <= next_a[9:0];
            end
            if (is_dual && (res2 || key_reset_ev)) begin
                pv_b <= '0;
                frac_b <= '0;
            end else if (is_dual && pulse_b) begin
                pv_b <= next_b[29:10];
                frac_b <= next_b[9:0];
            end
            // total runs on its own; completion never clears it
            if ((is_total && res2) || (is_total && key_reset_ev)) begin
                total <= '0;
                frac_t <= '0;
            end else if (pulse_a && !res1) begin
                total <= next_t[29:10];
                frac_t <= next_t[9:0];
            end
            if (is_batch && (res2 || key_reset_ev)) begin
                batch <= '0;
                batch_done <= 1'b0;
            end else begin
                if (is_batch && complete)
                    batch <= next_batch;
                if (is_batch && batch_set != 20'h0 && batch >= batch_set)
                    batch_done <= 1'b1;
            end
        end
    end

    // outputs: level or one-shot, restored after supply loss
    wire oneshot = ctrl[pcc_pkg::C_ONESHOT];
    wire os_tick = os_tick_cnt + 32'h1 >= OS_TICK;
    wire clear_out = res1 || key_reset_ev;
    logic restored;
    always_ff @(posedge mclk) begin
        if (rst) begin
            stage1_output <= 1'b0;
            stage2_output <= 1'b0;
            os_active <= 1'b0;
            os_left <= '0;
            os_tick_cnt <= '0;
            restored <= 1'b0;
        end else begin
            restored <= 1'b1;
            os_tick_cnt <= (os_active && !os_tick) ? os_tick_cnt + 32'h1 : '0;
            if (!restored) begin
                // held states come back; ctrl is still reset, so a one-shot does not restart
                stage1_output <= restore_one;
                stage2_output <= restore_two;
                os_active <= oneshot && restore_two;
                os_left <= os_time;
            end else if (clear_out) begin
                stage1_output <= 1'b0;
                stage2_output <= 1'b0;
                os_active <= 1'b0;
            end else begin
                if (reach1)
                    stage1_output <= 1'b1;
                if (reach2 && !stage2_output) begin
                    stage2_output <= 1'b1;
                    os_active <= oneshot;
                    os_left <= os_time;
                end else if (os_active && os_tick) begin
                    if (os_left <= pcc_pkg::OS_TIME_MIN) begin
                        os_active <= 1'b0;
                        stage2_output <= 1'b0;
                    end
                    os_left <= os_left - 14'h1;
                end
            end
        end
    end

    // output allocation
    wire out_one = is_batch ? batch_done : (is_two ? stage1_output : stage2_output);
    wire drv_two = stage2_output;
    wire swap = ctrl[pcc_pkg::C_SWAP] && ctrl[pcc_pkg::C_TWO_STAGE];
    wire color_out = (is_two || is_batch) ? stage2_output : out_one;
    logic next_red;
    always_comb begin
        case (ctrl[pcc_pkg::C_COLOR_LO +: 2])
            pcc_pkg::PCC_COL_RED: next_red = 1'b1;
            pcc_pkg::PCC_COL_GREEN: next_red = 1'b0;
            pcc_pkg::PCC_COL_RED_GREEN: next_red = !color_out;
            default: next_red = color_out;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            transistor_out <= 1'b0;
            contact_out <= 1'b0;
            value_red <= 1'b1;
            value_green <= 1'b0;
        end else begin
            transistor_out <= swap ? drv_two : out_one;
            contact_out <= swap ? out_one : drv_two;
            value_red <= next_red;
            value_green <= !next_red;
        end
    end

    // register port; digit register steps one decimal digit of set value two
    function automatic logic [19:0] step_digit(input logic [19:0] v, input logic [2:0] d,
                                               input logic down);
        logic [19:0] p;
        logic [19:0] dig;
        p = 20'h1;
        for (int i = 0; i < 6; i++)
            if (i < int'(d))
                p = 20'(p * 20'd10);
        dig = (v / p) % 20'd10;
        if (down)
            step_digit = (dig == 20'h0) ? 20'(v + 20'd9 * p) : 20'(v - p);
        else
            step_digit = (dig == 20'd9) ? 20'(v - 20'd9 * p) : 20'(v + p);
    endfunction
    wire wr_ctrl = wr && addr == pcc_pkg::REG_CTRL;
    wire [16:0] ps_max = four ? pcc_pkg::PRESCALE_MAX_FOUR : pcc_pkg::PRESCALE_MAX_SIX;
    wire [16:0] ps_in = wdata[16:0];
    wire [13:0] os_in = wdata[13:0];
    logic [31:0] next_rdata;
    always_comb begin
        case (addr)
            pcc_pkg::REG_CTRL: next_rdata = {16'h0, ctrl};
            pcc_pkg::REG_PRESCALE: next_rdata = {15'h0, prescale};
            pcc_pkg::REG_SET_ONE: next_rdata = {12'h0, set_value_one};
            pcc_pkg::REG_SET_TWO: next_rdata = {12'h0, set_value_two};
            pcc_pkg::REG_BATCH_SET: next_rdata = {12'h0, batch_set};
            pcc_pkg::REG_OS_TIME: next_rdata = {18'h0, os_time};
            pcc_pkg::REG_PV: next_rdata = {12'h0, pv};
            pcc_pkg::REG_TOTAL: next_rdata = {12'h0, total};
            pcc_pkg::REG_BATCH: next_rdata = {12'h0, batch};
            pcc_pkg::REG_DUAL: next_rdata = {{11{dual_val[20]}}, dual_val};
            pcc_pkg::REG_STATUS: next_rdata = {26'h0, batch_done, os_active, locked, res1,
                                               stage1_output, stage2_output};
            default: next_rdata = 32'h0;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl <= pcc_pkg::CTRL_RESET;
            prescale <= pcc_pkg::PRESCALE_ONE;
            set_value_one <= '0;
            set_value_two <= '0;
            batch_set <= '0;
            os_time <= pcc_pkg::OS_TIME_RESET;
            rdata <= '0;
        end else begin
            rdata <= rd ? next_rdata : 32'h0;
            if (wr_ctrl)
                ctrl <= wdata[15:0];
            if (wr && addr == pcc_pkg::REG_PRESCALE && ps_in >= pcc_pkg::PRESCALE_MIN
                && ps_in <= ps_max)
                prescale <= ps_in;
            if (wr && addr == pcc_pkg::REG_SET_ONE && wdata[19:0] <= full_scale)
                set_value_one <= wdata[19:0];
            if (wr && addr == pcc_pkg::REG_SET_TWO && wdata[19:0] <= full_scale)
                set_value_two <= wdata[19:0];
            if (wr && addr == pcc_pkg::REG_BATCH_SET && wdata[19:0] <= full_scale)
                batch_set <= wdata[19:0];
            if (wr && addr == pcc_pkg::REG_OS_TIME && os_in >= pcc_pkg::OS_TIME_MIN
                && os_in <= pcc_pkg::OS_TIME_MAX)
                os_time <= os_in;
            if (wr && addr == pcc_pkg::REG_DIGIT && !blk_up && wdata[2:0] < (four ? 3'd4 : 3'd6))
                set_value_two <= step_digit(set_value_two, wdata[2:0], wdata[3]);
        end
    end
endmodule

// >>> rtl/pcc_pkg.sv
package pcc_pkg;
    localparam int CLK_HZ = 125000000;
    // timing figures as printed
    localparam int RST_WIDTH_LONG_MS = 20;
    localparam int RST_WIDTH_SHORT_MS = 1;
    localparam int HOLD_CONFIG_MS = 1000;
    localparam int HOLD_FUNC_MS = 3000;
    localparam int RATE_LOW_HZ = 30;
    localparam int RATE_HIGH_HZ = 5000;
    localparam int OS_TICK_MS = 10;
    localparam int MS_CYCLES = (CLK_HZ + 999) / 1000;
    localparam int RST_LONG_CYC = RST_WIDTH_LONG_MS * MS_CYCLES;
    localparam int RST_SHORT_CYC = RST_WIDTH_SHORT_MS * MS_CYCLES;
    localparam int HOLD_CONFIG_CYC = HOLD_CONFIG_MS * MS_CYCLES;
    localparam int HOLD_FUNC_CYC = HOLD_FUNC_MS * MS_CYCLES;
    // half of the pulse period is the least level time at each rate
    localparam int RATE_LOW_CYC = (CLK_HZ + 2 * RATE_LOW_HZ - 1) / (2 * RATE_LOW_HZ);
    localparam int RATE_HIGH_CYC = (CLK_HZ + 2 * RATE_HIGH_HZ - 1) / (2 * RATE_HIGH_HZ);
    localparam int OS_TICK_CYC = OS_TICK_MS * MS_CYCLES;
    // count limits
    localparam logic [19:0] FULL_SCALE_SIX = 20'hf423f;
    localparam logic [19:0] FULL_SCALE_FOUR = 20'h0270f;
    localparam logic [16:0] PRESCALE_MIN = 17'h00001;
    localparam logic [16:0] PRESCALE_MAX_SIX = 17'h1869f;
    localparam logic [16:0] PRESCALE_MAX_FOUR = 17'h0270f;
    localparam logic [16:0] PRESCALE_ONE = 17'h003e8;
    localparam logic [13:0] OS_TIME_MIN = 14'h0001;
    localparam logic [13:0] OS_TIME_MAX = 14'h270f;
    localparam logic [13:0] OS_TIME_RESET = 14'h0032;
    // register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_PRESCALE = 4'h1;
    localparam logic [3:0] REG_SET_ONE = 4'h2;
    localparam logic [3:0] REG_SET_TWO = 4'h3;
    localparam logic [3:0] REG_BATCH_SET = 4'h4;
    localparam logic [3:0] REG_OS_TIME = 4'h5;
    localparam logic [3:0] REG_PV = 4'h6;
    localparam logic [3:0] REG_TOTAL = 4'h7;
    localparam logic [3:0] REG_BATCH = 4'h8;
    localparam logic [3:0] REG_DUAL = 4'h9;
    localparam logic [3:0] REG_STATUS = 4'ha;
    localparam logic [3:0] REG_DIGIT = 4'hb;
    // control field positions
    localparam int C_CFG_LO = 0;
    localparam int C_SOURCING = 3;
    localparam int C_RST_SHORT = 4;
    localparam int C_RATE_HIGH = 5;
    localparam int C_ONESHOT = 6;
    localparam int C_SWAP = 7;
    localparam int C_COLOR_LO = 8;
    localparam int C_LOCK_LO = 10;
    localparam int C_SUB = 13;
    localparam int C_FOUR = 14;
    localparam int C_TWO_STAGE = 15;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [2:0] LOCK_ONE = 3'h0;
    localparam logic [2:0] LOCK_TWO = 3'h1;
    localparam logic [2:0] LOCK_THREE = 3'h2;
    localparam logic [2:0] LOCK_FOUR = 3'h3;
    localparam logic [2:0] LOCK_FIVE = 3'h4;
    typedef enum logic [2:0] {
        PCC_CFG_SINGLE, PCC_CFG_TWO, PCC_CFG_TOTAL, PCC_CFG_BATCH, PCC_CFG_DUAL
    } pcc_cfg_t;
    typedef enum logic [1:0] {
        PCC_COL_RED, PCC_COL_GREEN, PCC_COL_RED_GREEN, PCC_COL_GREEN_RED
    } pcc_color_t;
endpackage

// >>> test/pcc_core_properties.sv
`timescale 1ns/10ps
module pcc_core_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic lock_switch,
    input wire logic lock_lit,
    input wire logic value_red,
    input wire logic value_green,
    input wire logic config_mode_req,
    input wire logic func_mode_req
);
    logic [15:0] ctrl;
    // pin judged by the polarity last written; a write makes a short glitch
    wire logic lock_on = lock_switch ~^ ctrl[pcc_pkg::C_SOURCING];
    wire logic [1:0] col = ctrl[pcc_pkg::C_COLOR_LO +: 2];
    always_ff @(posedge mclk) begin
        if (rst)
            ctrl <= pcc_pkg::CTRL_RESET;
        else if (wr && addr == pcc_pkg::REG_CTRL)
            ctrl <= wdata[15:0];
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_one_colour; value_red ^ value_green; endproperty
    property p_red; (col == 2'h0) [*3] |-> value_red; endproperty
    property p_green; (col == 2'h1) [*3] |-> value_green; endproperty
    property p_lock_on; ($stable(ctrl) && lock_on) [*8] |-> lock_lit; endproperty
    property p_lock_off; ($stable(ctrl) && !lock_on) [*8] |-> !lock_lit; endproperty
    property p_blocked; lock_lit [*3] |-> !func_mode_req && !config_mode_req; endproperty
    property p_func; func_mode_req |=> !func_mode_req; endproperty
    property p_cfg; config_mode_req |=> !config_mode_req; endproperty
    property p_rdata; !$past(rd) |-> rdata == 32'h0; endproperty
    a_one_colour: assert property (p_one_colour) else $error("colour");
    a_red: assert property (p_red) else $error("red");
    a_green: assert property (p_green) else $error("green");
    a_lock_on: assert property (p_lock_on) else $error("lock on");
    a_lock_off: assert property (p_lock_off) else $error("lock off");
    a_blocked: assert property (p_blocked) else $error("mode while locked");
    a_func: assert property (p_func) else $error("func pulse");
    a_cfg: assert property (p_cfg) else $error("config pulse");
    a_rdata: assert property (p_rdata) else $error("rdata idle");
    c_lock: cover property (lock_lit);
    c_func: cover property (func_mode_req);
    c_green: cover property (value_green);
endmodule
bind pcc_core pcc_core_checker i_chk (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .lock_switch, .lock_lit, .value_red, .value_green, .config_mode_req, .func_mode_req);

// >>> test/pcc_field.sv
`timescale 1ns/10ps
module pcc_field (
    input wire logic mclk,
    input wire logic sourcing,
    output logic [8:0] pins
);
    logic [8:0] act = 9'h0;
    // one polarity for every pin, idle high when sinking
    assign pins = sourcing ? act : ~act;
    task automatic level(input int idx, input logic v);
        @(posedge mclk);
        act[idx] <= v;
    endtask
    // each level held cyc cycles so the rate filter keeps it
    task automatic hold(input int idx, input int cyc);
        @(posedge mclk);
        act[idx] <= 1'b1;
        repeat (cyc) @(posedge mclk);
        act[idx] <= 1'b0;
        repeat (cyc) @(posedge mclk);
    endtask
endmodule

// >>> test/tb_preset_counter_core.sv
`timescale 1ns/10ps
module tb_preset_counter_core;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sourcing = 1'b0;
    logic rs_one = 1'b0;
    logic rs_two = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [8:0] p;
    logic t_o, c_o, red, grn, lit, cfg, fn, dnx;
    int err_count = 0;
    int checks = 0;
    int fn_seen = 0;
    int cfg_seen = 0;
    int dn_seen = 0;
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        if (fn === 1'b1)
            fn_seen++;
        if (cfg === 1'b1)
            cfg_seen++;
        if (dnx === 1'b1)
            dn_seen++;
    end
    pcc_field i_fld (.mclk(mclk), .sourcing(sourcing), .pins(p));
    // short reset, fast rate and one-shot timings keep defaults: no scenario selects them
    pcc_core #(.RST_LONG(20), .HOLD_CONFIG(10), .HOLD_FUNC(20), .RATE_LOW(8)) i_dut (
        .mclk(mclk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .count_input_a(p[0]),
        .count_input_b(p[1]), .reset_in_one(p[2]), .reset_in_two(p[3]), .key_mode(p[4]),
        .key_up(p[5]), .key_reset(p[6]), .key_display(p[7]), .lock_switch(p[8]),
        .restore_one(rs_one), .restore_two(rs_two), .transistor_out(t_o), .contact_out(c_o),
        .value_red(red), .value_green(grn), .lock_lit(lit), .config_mode_req(cfg),
        .func_mode_req(fn), .display_next(dnx));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input string what, input logic [3:0] a, input logic [31:0] exp);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(what, rdata, exp);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic t_scale;
        rchk("prescale", pcc_pkg::REG_PRESCALE, 32'h3e8);
        wreg(pcc_pkg::REG_OS_TIME, 32'h0);
        rchk("os time", pcc_pkg::REG_OS_TIME, 32'h32);
        rchk("unmapped", 4'hf, 32'h0);
        wreg(pcc_pkg::REG_PRESCALE, 32'h1f4);
        repeat (3) i_fld.hold(0, 12);
        rchk("pv half", pcc_pkg::REG_PV, 32'h1);
        i_fld.hold(0, 12);
        rchk("pv", pcc_pkg::REG_PV, 32'h2);
        $display("scale done");
    endtask
    task automatic t_reset;
        i_fld.hold(2, 5);
        rchk("pv short", pcc_pkg::REG_PV, 32'h2);
        i_fld.level(2, 1'b1);
        repeat (30) @(posedge mclk);
        i_fld.hold(0, 12);
        rchk("pv held", pcc_pkg::REG_PV, 32'h0);
        rchk("total held", pcc_pkg::REG_TOTAL, 32'h2);
        i_fld.level(2, 1'b0);
        repeat (30) @(posedge mclk);
        $display("reset done");
    endtask
    task automatic t_output;
        wreg(pcc_pkg::REG_PRESCALE, 32'h3e8);
        wreg(pcc_pkg::REG_SET_ONE, 32'h3);
        wreg(pcc_pkg::REG_SET_TWO, 32'h3);
        wreg(pcc_pkg::REG_CTRL, 32'h8200);
        repeat (2) i_fld.hold(0, 12);
        chk("outs", {30'h0, t_o, c_o}, 32'h0);
        // stop at the set value so it is never reached twice
        i_fld.hold(0, 12);
        chk("outs", {30'h0, t_o, c_o}, 32'h3);
        chk("green", {31'h0, grn}, 32'h1);
        $display("output done");
    endtask
    task automatic t_lock;
        i_fld.level(8, 1'b1);
        i_fld.hold(4, 30);
        chk("lit", {31'h0, lit}, 32'h1);
        chk("func locked", fn_seen, 32'h0);
        i_fld.hold(7, 6);
        chk("display", dn_seen, 32'h1);
        i_fld.level(8, 1'b0);
        i_fld.hold(4, 30);
        chk("func", fn_seen, 32'h1);
        i_fld.level(5, 1'b1);
        i_fld.hold(4, 30);
        i_fld.level(5, 1'b0);
        chk("config", cfg_seen, 32'h1);
        chk("func none", fn_seen, 32'h1);
        wreg(pcc_pkg::REG_CTRL, 32'h8208);
        sourcing <= 1'b1;
        i_fld.level(8, 1'b1);
        repeat (10) @(posedge mclk);
        chk("lit src", {31'h0, lit}, 32'h1);
        $display("lock done");
    endtask
    // supply loss: outputs held on must come back after a mid-run reset
    task automatic t_restore;
        i_fld.level(8, 1'b0);
        rst <= 1'b1;
        sourcing <= 1'b0;
        rs_one <= 1'b1;
        rs_two <= 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("restored", {30'h0, t_o, c_o}, 32'h3);
        rchk("status", pcc_pkg::REG_STATUS, 32'h3);
        $display("restore done");
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_scale;
        t_reset;
        t_output;
        t_lock;
        t_restore;
        end_sim;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        end_sim;
    end
endmodule
